// ---- core/fps_map.vh ----
// Constants for the flash protect-bit and status sequencer.
// Included by the sequencer; its protect-bit store does not include it.
`ifndef FPS_MAP_VH
`define FPS_MAP_VH
// Command codes written by the CPU.
`define FPS_CMD_PROTECT     16'h0067
`define FPS_CMD_READ_PROT   16'h0061
`define FPS_CMD_CLEAR_STAT  16'h0050
`define FPS_CMD_READ_ARRAY  16'h00FF
`define FPS_CMD_READ_STAT   16'h0070
`define FPS_CMD_CONFIRM     16'h00D0
// Register byte offsets on the Avalon slave.
`define FPS_REG_CMD_ADDR    6'h00
`define FPS_REG_CMD_DATA    6'h04
`define FPS_REG_STATUS      6'h08
`define FPS_REG_MODE        6'h0C
`define FPS_REG_IRQ_STAT    6'h10
`define FPS_REG_IRQ_MASK    6'h14
`define FPS_REG_READ_ADDR   6'h18
`define FPS_REG_READ_DATA   6'h1C
`define FPS_REG_PROT_BITS   6'h20
// Status register bit positions.
`define FPS_SR_READY        7
`define FPS_SR_ERASE        5
`define FPS_SR_PROGRAM      4
// Interrupt status bit positions.
`define FPS_IRQ_DONE        0
`define FPS_IRQ_ERROR       1
// Command address and flash window.
`define FPS_CMD_ADDRESS     32'hFFFFF800
`define FPS_FLASH_BASE      32'hFFF00000
`define FPS_FLASH_LAST      32'hFFFFFFFF
// Protect-bit program time.
`define FPS_PROG_TIME_NS    10000
`define FPS_CLOCK_NS        50
`define FPS_PROG_CYCLES     ((`FPS_PROG_TIME_NS + `FPS_CLOCK_NS - 1) / `FPS_CLOCK_NS)
`endif

// ---- core/fps_protect_store.v ----
// Protect-bit store: two protect bits per block, cleared one at a time.
// Assumes the sequencer pulses clear_en with a valid index and bit select.
`timescale 1ns/1ps
`default_nettype none
module fps_protect_store
#(
  parameter BLOCKS = 16,
  parameter IDX_W  = 4
)
(
  // Clock and reset
  input  wire               clock,
  input  wire               rst_n,
  // Clear request
  input  wire               clear_en,
  input  wire [IDX_W-1:0]   clear_block,
  input  wire               clear_sel,
  // Status
  output wire [BLOCKS-1:0]  block_protected,
  output wire [2*BLOCKS-1:0] bits
);
  reg [2*BLOCKS-1:0] prot_bits;
  assign bits = prot_bits;
  genvar g;
  generate
    for (g = 0; g < BLOCKS; g = g + 1)
    begin : blk
      localparam [IDX_W-1:0] IDX = g;
      always @(posedge clock)
      begin
        if (!rst_n)
        begin
          prot_bits[2*g+1:2*g] <= 2'b11;
        end
        else if (clear_en && (clear_block == IDX))
        begin
          prot_bits[2*g+clear_sel] <= 1'b0;
        end
      end
      // Any programmed bit protects the whole block.
      assign block_protected[g] = ~&prot_bits[2*g+1:2*g]; // R02
    end
  endgenerate
endmodule // fps_protect_store
`default_nettype wire

// ---- core/fps_sequencer.v ----
// Flash command sequencer for protect-bit program and status reads.
// Assumes an Avalon-MM master; commands are the CMD_ADDR then CMD_DATA pair.
//
// Decided for this implementation: the Avalon-MM interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "fps_map.vh"
// Notes on behaviour
// R01: 0067h then 00D0h clears protect bit.
// R02: Any programmed protect bit protects block.
// R03: Ready flag low while programming runs.
// R04: Software verifies via protect status read.
// R05: 0061h enters read protect status mode.
// R06: Reads then return addressed block protection.
// R07: Mode entry command issued from RAM.
// R08: Error flags mirror status erase/program bits.
// R09: Bad confirm data sets both errors.
// R10: Unavailable address sets both errors.
// R11: Erase errors set erase flag only.
// R12: Program on locked block sets write error.
// R13: Failed protect program sets write error.
// R14: Software clears status after errors.
// R15: 0050h clears both error bits.
// R16: Commands only while ready reads one.
// R17: Completion returns per erase-write mode.
// R18: 00FFh second write cancels silently.
module fps_sequencer
#(
  parameter BLOCKS      = 16,
  parameter IDX_W       = 4,
  parameter PROG_CYCLES = `FPS_PROG_CYCLES
)
(
  // Clock and reset
  input  wire         clock,
  input  wire         rst_n,
  // Avalon-MM slave
  input  wire [5:0]   avs_address,
  input  wire         avs_read,
  input  wire         avs_write,
  input  wire [31:0]  avs_writedata,
  output reg  [31:0]  avs_readdata,
  output reg          avs_waitrequest,
  // Status outputs
  output reg          irq,
  output reg          access_pending_flag,
  output reg          erase_error_flag,
  output reg          write_error_flag,
  // Program fault injection from the array
  input  wire         prog_fail
);
  localparam ST_IDLE = 2'b00;
  localparam ST_ARM  = 2'b01;
  localparam ST_BUSY = 2'b10;
  localparam MD_ARRAY = 2'b00;
  localparam MD_STAT  = 2'b01;
  localparam MD_PROT  = 2'b10;

  reg  [1:0]   state;
  reg  [1:0]   read_mode;
  reg  [31:0]  cmd_addr;
  reg  [31:0]  read_addr;
  reg          status_erase_bit;
  reg          status_program_bit;
  reg          seq_ready;
  reg          erase_write_mode_one;
  reg  [1:0]   irq_stat;
  reg  [1:0]   irq_mask;
  reg  [15:0]  busy_cnt;
  reg  [IDX_W-1:0] tgt_block;
  reg          tgt_sel;
  reg          fail_s1;
  reg          fail_s2;
  reg          done_ev;
  reg          err_ev;
  wire [BLOCKS-1:0]   block_protected;
  wire [2*BLOCKS-1:0] prot_bits;
  wire         clear_en;
  wire         acc;
  wire [15:0]  wdata;
  wire [2*BLOCKS+31:0] prot_ext;

  assign acc   = (avs_read | avs_write) & avs_waitrequest;
  assign wdata = avs_writedata[15:0];
  assign prot_ext = {32'h00000000, prot_bits};
  assign clear_en = (state == ST_BUSY) && (busy_cnt == 16'h0001) && !fail_s2;

  // ----------------------------------------------------------------
  // Address checks
  // ----------------------------------------------------------------
  function in_flash;
    input [31:0] a;
    begin
      in_flash = (a >= `FPS_FLASH_BASE) && (a <= `FPS_FLASH_LAST);
    end
  endfunction

  // Each block covers 64 KB; bit 1 of the address picks one of two bits.
  function [IDX_W-1:0] block_of;
    input [31:0] a;
    begin
      block_of = a[16+IDX_W-1:16];
    end
  endfunction

  fps_protect_store #(.BLOCKS(BLOCKS), .IDX_W(IDX_W)) u_store
  (
    .clock           (clock),
    .rst_n           (rst_n),
    .clear_en        (clear_en),
    .clear_block     (tgt_block),
    .clear_sel       (tgt_sel),
    .block_protected (block_protected),
    .bits            (prot_bits)
  );

  // ----------------------------------------------------------------
  // Command sequencer
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      fail_s1 <= 1'b0;
      fail_s2 <= 1'b0;
    end
    else
    begin
      fail_s1 <= prog_fail;
      fail_s2 <= fail_s1;
    end
  end

  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      state               <= ST_IDLE;
      read_mode           <= MD_ARRAY;
      cmd_addr            <= 32'h00000000;
      read_addr           <= 32'h00000000;
      status_erase_bit    <= 1'b0;
      status_program_bit  <= 1'b0;
      seq_ready           <= 1'b1;
      erase_write_mode_one <= 1'b0;
      busy_cnt            <= 16'h0000;
      tgt_block           <= {IDX_W{1'b0}};
      tgt_sel             <= 1'b0;
      access_pending_flag <= 1'b0;
      done_ev             <= 1'b0;
      err_ev              <= 1'b0;
    end
    else
    begin
      done_ev <= 1'b0;
      err_ev  <= 1'b0;
      access_pending_flag <= 1'b0;
      if (state == ST_BUSY)
      begin
        if (busy_cnt == 16'h0001)
        begin
          state     <= ST_IDLE;
          seq_ready <= 1'b1; // R03
          done_ev   <= 1'b1;
          if (fail_s2)
          begin
            status_program_bit <= 1'b1; // R12 R13
            err_ev             <= 1'b1;
          end
          read_mode <= erase_write_mode_one ? MD_ARRAY : MD_STAT; // R17
        end
        busy_cnt <= busy_cnt - 16'h0001;
      end
      if (acc && avs_write)
      begin
        if (avs_address == `FPS_REG_CMD_ADDR)
        begin
          cmd_addr <= avs_writedata;
        end
        else if (avs_address == `FPS_REG_READ_ADDR)
        begin
          read_addr <= avs_writedata;
        end
        else if (avs_address == `FPS_REG_MODE)
        begin
          erase_write_mode_one <= avs_writedata[0];
        end
        else if (avs_address == `FPS_REG_CMD_DATA && seq_ready) // R16
        begin
          access_pending_flag <= 1'b1;
          if (state == ST_ARM)
          begin
            state <= ST_IDLE;
            if (wdata == `FPS_CMD_READ_ARRAY)
            begin
              read_mode <= MD_ARRAY; // R18
            end
            else if (wdata != `FPS_CMD_CONFIRM || !in_flash(cmd_addr))
            begin
              status_erase_bit   <= 1'b1; // R09 R10
              status_program_bit <= 1'b1;
              err_ev             <= 1'b1;
            end
            else
            begin
              tgt_block <= block_of(cmd_addr); // R01
              tgt_sel   <= cmd_addr[1];
              state     <= ST_BUSY;
              seq_ready <= 1'b0; // R03
              busy_cnt  <= PROG_CYCLES[15:0];
            end
          end
          else if (cmd_addr != `FPS_CMD_ADDRESS)
          begin
            status_erase_bit   <= 1'b1; // R10
            status_program_bit <= 1'b1;
            err_ev             <= 1'b1;
          end
          else if (wdata == `FPS_CMD_PROTECT)
          begin
            state <= ST_ARM; // R01
          end
          else if (wdata == `FPS_CMD_READ_PROT)
          begin
            read_mode <= MD_PROT; // R05
          end
          else if (wdata == `FPS_CMD_CLEAR_STAT)
          begin
            status_erase_bit   <= 1'b0; // R15
            status_program_bit <= 1'b0;
          end
          else if (wdata == `FPS_CMD_READ_STAT)
          begin
            read_mode <= MD_STAT;
          end
          else if (wdata == `FPS_CMD_READ_ARRAY)
          begin
            read_mode <= MD_ARRAY;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // Flags and interrupt
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      erase_error_flag <= 1'b0;
      write_error_flag <= 1'b0;
      irq_stat         <= 2'b00;
      irq_mask         <= 2'b00;
      irq              <= 1'b0;
    end
    else
    begin
      erase_error_flag <= status_erase_bit; // R08
      write_error_flag <= status_program_bit;
      if (acc && avs_write && avs_address == `FPS_REG_IRQ_MASK)
      begin
        irq_mask <= avs_writedata[1:0];
      end
      // A new event wins over the read that clears.
      if (acc && avs_read && avs_address == `FPS_REG_IRQ_STAT)
      begin
        irq_stat <= {err_ev, done_ev};
      end
      else
      begin
        irq_stat <= irq_stat | {err_ev, done_ev};
      end
      irq <= |(irq_stat & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always @(posedge clock)
  begin
    if (!rst_n)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h00000000;
    end
    else
    begin
      avs_waitrequest <= ~acc;
      if (acc && avs_read)
      begin
        if (avs_address == `FPS_REG_STATUS)
        begin
          avs_readdata <= {24'h000000, seq_ready, 1'b0, status_erase_bit,
                           status_program_bit, 4'h0};
        end
        else if (avs_address == `FPS_REG_MODE)
        begin
          avs_readdata <= {28'h0000000, read_mode, 1'b0, erase_write_mode_one};
        end
        else if (avs_address == `FPS_REG_IRQ_STAT)
        begin
          avs_readdata <= {30'h00000000, irq_stat};
        end
        else if (avs_address == `FPS_REG_IRQ_MASK)
        begin
          avs_readdata <= {30'h00000000, irq_mask};
        end
        else if (avs_address == `FPS_REG_CMD_ADDR)
        begin
          avs_readdata <= cmd_addr;
        end
        else if (avs_address == `FPS_REG_READ_ADDR)
        begin
          avs_readdata <= read_addr;
        end
        else if (avs_address == `FPS_REG_PROT_BITS)
        begin
          avs_readdata <= prot_ext[31:0];
        end
        else if (avs_address == `FPS_REG_READ_DATA)
        begin
          if (read_mode == MD_PROT)
          begin
            avs_readdata <= {25'h0000000, ~block_protected[block_of(read_addr)],
                             6'h00}; // R06
          end
          else if (read_mode == MD_STAT)
          begin
            avs_readdata <= {24'h000000, seq_ready, 1'b0, status_erase_bit,
                             status_program_bit, 4'h0};
          end
          else
          begin
            avs_readdata <= 32'h0000FFFF;
          end
        end
        else
        begin
          avs_readdata <= 32'h00000000;
        end
      end
    end
  end
endmodule // fps_sequencer
`default_nettype wire

// ---- tb/fps_seq_sva.sv ----
// Concurrent checks on the flash protect-bit sequencer's slave port and flags.
// Assumes one clock domain and the synchronous active-low reset of the sequencer.
`timescale 1ns/1ps
`default_nettype none
module fps_seq_sva
(
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rst_n,
  // Bus
  input  wire logic [5:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest,
  // Flags
  input  wire logic        access_pending_flag,
  input  wire logic        erase_error_flag,
  input  wire logic        write_error_flag
);
  // ---------------------------------------------
  // Helper and assertions
  // ---------------------------------------------
  wire data_wr;
  assign data_wr = avs_write && (avs_address == 6'h04);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_ACK_NEXT: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("access not answered in the next cycle");
  AST_ACK_ONE: assert property (!avs_waitrequest |=> avs_waitrequest)
    else $error("waitrequest low for more than one cycle");
  AST_ACK_CAUSE: assert property (!avs_waitrequest |-> avs_read || avs_write)
    else $error("waitrequest low without a request");
  AST_RDATA_HOLD: assert property (!$stable(avs_readdata) |-> !avs_waitrequest && avs_read)
    else $error("read data changed outside a read answer");
  AST_PEND_PULSE: assert property (access_pending_flag |=> !access_pending_flag)
    else $error("pending flag longer than one cycle");
  AST_PEND_CAUSE: assert property (access_pending_flag |-> $past(data_wr) || $past(data_wr, 2))
    else $error("pending flag without a command data write");
  AST_ERR_PAIR: assert property ($rose(erase_error_flag) |-> write_error_flag)
    else $error("erase error raised without write error");
  AST_ERR_CLR: assert property ($fell(write_error_flag) |-> $past(data_wr, 2) || $past(data_wr, 3))
    else $error("write error cleared without a command write");
  AST_ERR_BOTH: assert property ($fell(erase_error_flag) |-> !write_error_flag)
    else $error("error flags not cleared together");
endmodule // fps_seq_sva

bind fps_sequencer fps_seq_sva fps_seq_sva_inst
(
  .clock               (clock),
  .rst_n               (rst_n),
  .avs_address         (avs_address),
  .avs_read            (avs_read),
  .avs_write           (avs_write),
  .avs_readdata        (avs_readdata),
  .avs_waitrequest     (avs_waitrequest),
  .access_pending_flag (access_pending_flag),
  .erase_error_flag    (erase_error_flag),
  .write_error_flag    (write_error_flag)
);
`default_nettype wire

// ---- tb/testbench.sv ----
// Self-checking bench for the flash protect-bit sequencer.
// Drives the Avalon slave and the program-fail input directly.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [5:0]  avs_address = 6'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic        prog_fail = 1'b0;
  wire  [31:0] avs_readdata;
  wire         avs_waitrequest;
  wire         irq;
  wire         access_pending_flag;
  wire         erase_error_flag;
  wire         write_error_flag;
  logic [31:0] rdat;
  logic [55:0] rows [0:9];
  int          mismatches = 0;
  int          n_tests = 0;
  int          i;

  fps_sequencer #(.BLOCKS(16), .IDX_W(4), .PROG_CYCLES(8)) fps_sequencer_inst
  (
    .clock               (clock),
    .rst_n               (rst_n),
    .avs_address         (avs_address),
    .avs_read            (avs_read),
    .avs_write           (avs_write),
    .avs_writedata       (avs_writedata),
    .avs_readdata        (avs_readdata),
    .avs_waitrequest     (avs_waitrequest),
    .irq                 (irq),
    .access_pending_flag (access_pending_flag),
    .erase_error_flag    (erase_error_flag),
    .write_error_flag    (write_error_flag),
    .prog_fail           (prog_fail)
  );

  initial
  begin
    forever #25 clock = ~clock;
  end

  // ---------------------------------------------
  // Tasks
  // ---------------------------------------------
  task stop_test;
    begin
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
        $display("NO MISMATCHES");
      else
        $display("MISMATCHES SEEN");
      $finish;
    end
  endtask

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    begin
      n_tests++;
      if (g !== e)
      begin
        $display("[ERR] %s expected %h seen %h", n, e, g);
        mismatches++;
      end
    end
  endtask

  // One Avalon access; the request is held until waitrequest is sampled low.
  task bus(input logic w, input logic [5:0] a, input logic [31:0] d);
    int t;
    begin
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      t = 0;
      do
      begin
        @(posedge clock);
        t++;
      end
      while (avs_waitrequest !== 1'b0 && t < 20);
      rdat = avs_readdata;
      if (avs_waitrequest !== 1'b0)
      begin
        chk("waitrequest", 32'h0, {31'h0, avs_waitrequest});
        stop_test();
      end
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clock);
    end
  endtask

  task cmd(input logic [31:0] a, input logic [15:0] c);
    begin
      chk("pending", 32'h0, {31'h0, access_pending_flag});
      bus(1'b1, 6'h00, a);
      bus(1'b1, 6'h04, {16'h0, c});
    end
  endtask

  task rdy;
    int t;
    begin
      t = 0;
      do
      begin
        bus(1'b0, 6'h08, 32'h0);
        t++;
      end
      while (rdat[7] !== 1'b1 && t < 40);
      if (rdat[7] !== 1'b1)
      begin
        chk("ready", 32'h80, rdat & 32'h80);
        stop_test();
      end
    end
  endtask

  // ---------------------------------------------
  // Sequence
  // ---------------------------------------------
  initial
  begin
    rows[0] = 56'hFFFFF800_0067_80;
    rows[1] = 56'hFFF30000_00D0_80;
    rows[2] = 56'hFFFFF800_0067_80;
    rows[3] = 56'hFFF30000_0012_B0;
    rows[4] = 56'hFFFFF800_0050_80;
    rows[5] = 56'hFFF10000_0061_B0;
    rows[6] = 56'hFFFFF800_0050_80;
    rows[7] = 56'hFFFFF800_0067_80;
    rows[8] = 56'hFFF30000_00FF_80;
    rows[9] = 56'hFFFFF800_0061_80;
    repeat (8) @(posedge clock);
    rst_n <= 1'b1;
    @(posedge clock);
    bus(1'b0, 6'h08, 32'h0);
    chk("reset status", 32'h80, rdat & 32'hB0);
    chk("reset flags", 32'h0, {29'h0, irq, erase_error_flag, write_error_flag});
    bus(1'b0, 6'h3C, 32'h0);
    chk("unmapped", 32'h0, rdat);
    $display("reset test end");
    for (i = 0; i < 10; i++)
    begin
      cmd(rows[i][55:24], rows[i][23:8]);
      rdy();
      chk("status", {24'h0, rows[i][7:0]}, rdat & 32'hB0);
    end
    bus(1'b0, 6'h0C, 32'h0);
    chk("mode", 32'h8, rdat & 32'hC);
    bus(1'b1, 6'h18, 32'hFFF30000);
    bus(1'b0, 6'h1C, 32'h0);
    chk("block 3", 32'h0, rdat & 32'h40);
    bus(1'b1, 6'h18, 32'hFFF40002);
    bus(1'b0, 6'h1C, 32'h0);
    chk("block 4", 32'h40, rdat & 32'h40);
    $display("row test end");
    bus(1'b0, 6'h10, 32'h0);
    bus(1'b1, 6'h14, 32'h2);
    bus(1'b0, 6'h14, 32'h0);
    chk("irq mask", 32'h2, rdat);
    cmd(32'hFFFFF800, 16'h0067);
    cmd(32'hFFF50002, 16'h00D0);
    bus(1'b0, 6'h08, 32'h0);
    chk("busy", 32'h0, rdat & 32'h80);
    rdy();
    bus(1'b0, 6'h0C, 32'h0);
    chk("mode ew0", 32'h4, rdat & 32'hC);
    bus(1'b0, 6'h1C, 32'h0);
    chk("status read", 32'h80, rdat & 32'hB0);
    chk("irq masked", 32'h0, {31'h0, irq});
    prog_fail <= 1'b1;
    cmd(32'hFFFFF800, 16'h0067);
    cmd(32'hFFF60000, 16'h00D0);
    rdy();
    prog_fail <= 1'b0;
    chk("fail status", 32'h90, rdat & 32'hB0);
    chk("fail flags", 32'h5, {29'h0, irq, erase_error_flag, write_error_flag});
    bus(1'b0, 6'h10, 32'h0);
    chk("irq status", 32'h2, rdat & 32'h2);
    @(posedge clock);
    chk("irq cleared", 32'h0, {31'h0, irq});
    cmd(32'hFFFFF800, 16'h0050);
    repeat (2) @(posedge clock);
    chk("cleared flags", 32'h0, {30'h0, erase_error_flag, write_error_flag});
    $display("error test end");
    bus(1'b1, 6'h0C, 32'h1);
    cmd(32'hFFFFF800, 16'h0067);
    cmd(32'hFFF70000, 16'h00D0);
    rdy();
    bus(1'b0, 6'h0C, 32'h0);
    chk("mode ew1", 32'h0, rdat & 32'hC);
    bus(1'b0, 6'h1C, 32'h0);
    chk("array read", 32'h0000FFFF, rdat);
    cmd(32'hFFFFF800, 16'h0070);
    bus(1'b0, 6'h0C, 32'h0);
    chk("mode status", 32'h4, rdat & 32'hC);
    bus(1'b0, 6'h20, 32'h0);
    chk("protect bits", 32'hFFFFB7BF, rdat);
    $display("mode test end");
    stop_test();
  end
endmodule // testbench
`default_nettype wire
